// ==== design/pcs_sequencer.sv ====
// conversion sequencer: power-down, filter select, settling, ready and word
//
// Notes on behaviour
// RL1: power-down low opens bridge switch
// RL2: power-down low resets logic, tristates pin
// RL3: release: close switch, wake 1 ms, convert
// RL4: filter low: 16.7 Hz, 120 ms settle
// RL5: filter high: 10 Hz, 300 ms settle
// RL6: filter change restarts, ready high immediately
// RL7: no result before full settling time
// RL8: settle spans three or two conversions
// RL9: later results follow the update rate
// RL10: ready stays high through new settling
// RL11: host finishes reads before filter change
// RL12: host discards unsettled results after steps
// RL13: every completed conversion is stored; the code stores only the last settle conversion and each run conversion
// RL14: ready low when new result stored
// RL15: word is 24-bit value plus status
// RL16: unread result: ready high before update
// RL17: serial interface reset on each result
// RL18: control pins synchronised, changes by comparison
`timescale 1ns/1ps
module pcs_sequencer import pcs_pkg::*; #(
   parameter int WAKE_CYC_P  = WAKE_CYC,       // oscillator wake time
   parameter int FAST_CYC_P  = CONV_FAST_CYC,  // fast conversion period
   parameter int SLOW_CYC_P  = CONV_SLOW_CYC,  // slow conversion period
   parameter int LEAD_CYC_P  = RDY_LEAD_CYC    // ready lead before update
) (
   input  wire logic        clock_i,               // internal oscillator
   input  wire logic        arst_n_i,              // async reset, low active
   input  wire logic        power_down_reset_n_i,  // power-down pin
   input  wire logic        filter_sel_i,          // filter select pin
   input  wire logic        sclk_i,                // host serial clock
   input  wire logic [23:0] filter_result_i,       // digital filter output
   output logic             bridge_switch_o,       // high: switch closed
   output logic             mod_reset_o,           // modulator/filter reset
   output logic             dout_rdy_o,            // ready / data pin value
   output logic             dout_rdy_oe_o,         // pin output enable
   output logic             filter_fast_o          // filter choice to datapath
);

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_meta_reg;   // first stage
   logic rst_n_reg;      // released reset used below

   // release through two flops so every clock_i flop below leaves reset on one edge
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg    <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg    <= rst_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic pd_meta_reg;     // power-down first stage
   logic pd_sync_reg;     // power-down synchronised, high = run
   logic flt_meta_reg;    // filter first stage
   logic flt_sync_reg;    // filter synchronised
   logic flt_q_reg;       // previous synchronised filter level

   // two flops each; the compare stage looks only at the second
   always_ff @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         pd_meta_reg  <= 1'b0;
         pd_sync_reg  <= 1'b0;
         flt_meta_reg <= 1'b0;
         flt_sync_reg <= 1'b0;
         flt_q_reg    <= 1'b0;
      end else begin
         pd_meta_reg  <= power_down_reset_n_i;  // RL18
         pd_sync_reg  <= pd_meta_reg;           // RL18
         flt_meta_reg <= filter_sel_i;          // RL18
         flt_sync_reg <= flt_meta_reg;          // RL18
         flt_q_reg    <= flt_sync_reg;
      end
   end

   // ----------------------------------------------------------------
   // read-done crossing from the serial clock
   // ----------------------------------------------------------------
   logic done_link;       // level from serial domain
   logic done_meta_reg;   // first stage
   logic done_sync_reg;   // safe to use

   always_ff @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         done_meta_reg <= 1'b0;
         done_sync_reg <= 1'b0;
      end else begin
         done_meta_reg <= done_link;
         done_sync_reg <= done_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   pcs_state_t        state_reg;     // sequencer state
   pcs_state_t        state_next;
   logic [CNT_W-1:0]  timer_reg;     // cycles into current interval
   logic [CNT_W-1:0]  timer_next;
   logic [CONV_W-1:0] conv_reg;      // conversions done in settle
   logic [CONV_W-1:0] conv_next;
   logic              rdy_reg;       // high: no result available
   logic              rdy_next;
   logic              mrst_reg;      // modulator reset
   pcs_word_t         word_reg;      // output data register

   wire               filt_change;   // filter pin changed level
   wire [CNT_W-1:0]   period_len;    // cycles per conversion
   wire [CONV_W-1:0]  settle_n;      // conversions per settle
   wire               period_end;    // last cycle of a conversion
   wire               wake_end;      // last cycle of wake-up
   wire               settle_last;   // final settle conversion
   wire               update;        // store a result this cycle
   wire               lead_hit;      // ready must rise now
   wire               converting;    // settle or run
   wire [7:0]         status_byte;   // appended status bits

   // a change is seen by comparing successive sampled levels
   assign filt_change = flt_sync_reg != flt_q_reg;  // RL18

   // high selects the slow, high-rejection filter
   assign period_len = flt_q_reg ? CNT_W'(SLOW_CYC_P)   // RL5
                                 : CNT_W'(FAST_CYC_P);  // RL4
   assign settle_n   = flt_q_reg ? CONV_W'(SETTLE_SLOW_CONV)   // RL8
                                 : CONV_W'(SETTLE_FAST_CONV);  // RL8

   assign period_end  = timer_reg == period_len - 1'b1;
   assign wake_end    = timer_reg == CNT_W'(WAKE_CYC_P - 1);  // RL3
   assign settle_last = conv_reg == settle_n - 1'b1;          // RL7
   assign converting  = (state_reg == ST_SETTLE) || (state_reg == ST_RUN);

   // no result leaves the settle phase until its last conversion
   assign update = pd_sync_reg && !filt_change && period_end &&
                   ((state_reg == ST_RUN) ||                        // RL9
                    ((state_reg == ST_SETTLE) && settle_last));     // RL7

   // the lead point assumes LEAD_CYC_P is shorter than one period
   assign lead_hit = (state_reg == ST_RUN) &&
                     (timer_reg == period_len - CNT_W'(LEAD_CYC_P) - 1'b1);

   // status: bits 7..4 zero, bit3 filter level, bits 2..0 check pattern
   assign status_byte = {4'h0, flt_q_reg, STATUS_PATTERN};  // RL15

   // ----------------------------------------------------------------
   // sequencer next state
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      timer_next = timer_reg + 1'b1;
      conv_next  = conv_reg;
      if (!pd_sync_reg) begin
         // power-down holds state, timer and conversion count at their idle values
         state_next = ST_DOWN;  // RL2
         timer_next = '0;
         conv_next  = '0;
      end else begin
         case (state_reg)
            ST_DOWN: begin
               // pin released: start oscillator wake-up
               state_next = ST_WAKE;  // RL3
               timer_next = '0;
            end
            ST_WAKE: begin
               if (wake_end) begin
                  state_next = ST_SETTLE;  // RL3
                  timer_next = '0;
                  conv_next  = '0;
               end
            end
            ST_SETTLE, ST_RUN: begin
               if (filt_change) begin
                  // restart with the newly chosen filter
                  state_next = ST_SETTLE;  // RL6
                  timer_next = '0;
                  conv_next  = '0;
               end else if (period_end) begin
                  timer_next = '0;
                  if (state_reg == ST_SETTLE) begin
                     if (settle_last) begin
                        state_next = ST_RUN;  // RL8
                     end else begin
                        conv_next = conv_reg + 1'b1;  // RL8
                     end
                  end
               end
            end
            default: begin
               state_next = ST_DOWN;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // ready flag next value
   // ----------------------------------------------------------------
   // priority: power-down and restart, then a new result, then the
   // host's read or the lead point; a result never loses to a clear
   always_comb begin
      rdy_next = rdy_reg;
      if (!pd_sync_reg || !converting || filt_change) begin
         rdy_next = 1'b1;  // RL10
      end else if (update) begin
         rdy_next = 1'b0;  // RL14
      end else if (lead_hit) begin
         rdy_next = 1'b1;  // RL16
      end else if (done_sync_reg) begin
         rdy_next = 1'b1;  // each result may be read once
      end
   end

   // ----------------------------------------------------------------
   // state registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         state_reg <= ST_DOWN;
         timer_reg <= '0;
         conv_reg  <= '0;
         rdy_reg   <= RDY_RST;
      end else begin
         state_reg <= state_next;
         timer_reg <= timer_next;
         conv_reg  <= conv_next;
         rdy_reg   <= rdy_next;
      end
   end

   // modulator and filter held in reset until converting, and pulsed
   // for one cycle on a filter change
   always_ff @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         mrst_reg <= 1'b1;
      end else begin
         mrst_reg <= !pd_sync_reg || !converting || filt_change;  // RL6
      end
   end

   // ----------------------------------------------------------------
   // output data register
   // ----------------------------------------------------------------
   // only the last settle conversion and each run conversion are stored
   always_ff @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         word_reg <= '0;
      end else if (update) begin
         word_reg <= '{value: filter_result_i, status: status_byte};  // RL13
      end
   end

   // ----------------------------------------------------------------
   // serial side
   // ----------------------------------------------------------------
   logic ser_bit;      // data bit from the shifter
   logic ser_active;   // transfer under way

   // the shifter is cleared while ready is high, so each new result
   // starts a fresh transfer and a late read only sees ones
   pcs_serial_shift pcs_serial_shift_inst (
      .sclk_i   (sclk_i),
      .clear_i  (rdy_reg),    // RL17
      .word_i   (word_reg),
      .dout_o   (ser_bit),
      .active_o (ser_active),
      .done_o   (done_link)
   );

   // ----------------------------------------------------------------
   // pins
   // ----------------------------------------------------------------
   // released only once the synchronised pin says run
   assign bridge_switch_o = pd_sync_reg;                     // RL1
   assign dout_rdy_oe_o   = pd_sync_reg;                     // RL2
   assign dout_rdy_o      = ser_active ? ser_bit : rdy_reg;
   assign mod_reset_o     = mrst_reg;
   assign filter_fast_o   = !flt_q_reg;                      // RL4

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] gap_reg;   // cycles since the last stored result, apart from the timer
   // restarts on a result, a filter change or power-down, so a bad timer shows up
   always_ff @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         gap_reg <= '0;
      end else begin
         gap_reg <= (update || filt_change || !pd_sync_reg) ? '0 : gap_reg + 1'b1;
      end
   end

   a_pd_switch_open: assert property ( // RL1
      @(posedge clock_i) disable iff (!rst_n_reg)
      !pd_sync_reg |-> !bridge_switch_o)
      else $error("bridge switch closed in power-down");

   a_pd_pin_float: assert property ( // RL2
      @(posedge clock_i) disable iff (!rst_n_reg)
      !pd_sync_reg |-> !dout_rdy_oe_o ##1 (state_reg == ST_DOWN && mod_reset_o))
      else $error("logic active or pin driven in power-down");

   a_wake_to_settle: assert property ( // RL3
      @(posedge clock_i) disable iff (!rst_n_reg)
      $rose(state_reg == ST_SETTLE) && $past(state_reg) == ST_WAKE
      |-> $past(timer_reg) == CNT_W'(WAKE_CYC_P - 1))
      else $error("wake-up left early or late");

   a_filt_restart: assert property ( // RL6
      @(posedge clock_i) disable iff (!rst_n_reg)
      converting && pd_sync_reg && filt_change
      |=> state_reg == ST_SETTLE && timer_reg == '0 && rdy_reg && mod_reset_o)
      else $error("filter change did not restart");

   a_settle_rdy_high: assert property ( // RL10
      @(posedge clock_i) disable iff (!rst_n_reg)
      state_reg == ST_SETTLE |-> rdy_reg)
      else $error("ready low during settling");

   a_settle_count: assert property ( // RL8
      @(posedge clock_i) disable iff (!rst_n_reg)
      update && state_reg == ST_SETTLE
      |-> conv_reg == (flt_q_reg ? 2'h2 : 2'h1) && period_end)
      else $error("first result not after full settle");

   a_update_period: assert property ( // RL9
      @(posedge clock_i) disable iff (!rst_n_reg)
      update && state_reg == ST_RUN |-> gap_reg == period_len - 1'b1)
      else $error("result off the update rate");

   a_update_store: assert property ( // RL13
      @(posedge clock_i) disable iff (!rst_n_reg)
      update |=> !rdy_reg && word_reg.value == $past(filter_result_i)
              && word_reg.status[2:0] == STATUS_PATTERN)
      else $error("result not stored or ready not low");

   a_lead_rdy_high: assert property ( // RL16
      @(posedge clock_i) disable iff (!rst_n_reg)
      lead_hit && pd_sync_reg && !filt_change |=> rdy_reg ##1 rdy_reg)
      else $error("ready not raised before update");

   c_filter_change: cover property (
      @(posedge clock_i) disable iff (!rst_n_reg)
      state_reg == ST_RUN && filt_change);

   c_first_result: cover property (
      @(posedge clock_i) disable iff (!rst_n_reg)
      update && state_reg == ST_SETTLE);

   c_read_done: cover property (
      @(posedge clock_i) disable iff (!rst_n_reg)
      !rdy_reg && done_sync_reg ##1 rdy_reg);

   c_wake_up: cover property (
      @(posedge clock_i) disable iff (!rst_n_reg)
      state_reg == ST_WAKE ##1 state_reg == ST_SETTLE);

endmodule // pcs_sequencer

// ==== design/pcs_pkg.sv ====
// package: constants, word layout and state type of the conversion sequencer
package pcs_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_KHZ          = 125000;  // core clock rate, 8 ns period
   localparam int T_WAKE_MS        = 1;       // oscillator power-up time
   localparam int T_SETTLE_FAST_MS = 120;     // fast filter settling time
   localparam int T_SETTLE_SLOW_MS = 300;     // high-rejection filter settling time
   localparam int SETTLE_FAST_CONV = 2;       // conversions per fast settle
   localparam int SETTLE_SLOW_CONV = 3;       // conversions per slow settle
   localparam int T_RDY_LEAD_US    = 100;     // ready rises this long before an update

   // derived cycle counts
   localparam int WAKE_CYC      = T_WAKE_MS * CLK_KHZ;
   localparam int CONV_FAST_CYC = T_SETTLE_FAST_MS * CLK_KHZ / SETTLE_FAST_CONV;
   localparam int CONV_SLOW_CYC = T_SETTLE_SLOW_MS * CLK_KHZ / SETTLE_SLOW_CONV;
   localparam int RDY_LEAD_CYC  = T_RDY_LEAD_US * CLK_KHZ / 1000;

   // ----------------------------------------------------------------
   // widths and reset values
   // ----------------------------------------------------------------
   localparam int CNT_W     = 24;      // holds the longest period count
   localparam int CONV_W    = 2;       // settle conversion counter
   localparam int WORD_BITS = 32;      // bits shifted per result
   localparam int BIT_CW    = 6;       // serial bit counter width
   localparam logic       RDY_RST        = 1'b1;    // no data after reset
   localparam logic [2:0] STATUS_PATTERN = 3'h5;    // fixed check pattern
   localparam int         ST_FILT_POS    = 3;       // status bit with filter

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   // result word: conversion value first, status byte last
   typedef struct packed {
      logic [23:0] value;
      logic [7:0]  status;
   } pcs_word_t;

   // sequencer states
   typedef enum logic [1:0] {
      ST_DOWN,
      ST_WAKE,
      ST_SETTLE,
      ST_RUN
   } pcs_state_t;

endpackage

// ==== design/pcs_serial_shift.sv ====
// serial shifter on the host serial clock
`timescale 1ns/1ps
module pcs_serial_shift import pcs_pkg::*; (
   input  wire logic      sclk_i,    // host serial clock
   input  wire logic      clear_i,   // async clear, high while no data
   input  wire pcs_word_t word_i,    // word held steady while clear is low
   output logic           dout_o,    // current data bit
   output logic           active_o,  // a transfer has begun
   output logic           done_o     // all bits taken by the host
);

   // ----------------------------------------------------------------
   // bit counter and data bit
   // ----------------------------------------------------------------
   logic [BIT_CW-1:0] cnt_reg;   // falling edges seen
   logic              bit_reg;   // bit on the pin
   logic [4:0]        idx;       // msb first

   assign idx      = 5'(WORD_BITS - 1) - cnt_reg[4:0];
   assign active_o = (cnt_reg != '0);
   assign dout_o   = bit_reg;

   // shift on falling edges; word is quasi-static, so no sync is needed
   always_ff @(negedge sclk_i or posedge clear_i) begin
      if (clear_i) begin
         cnt_reg <= '0;
         bit_reg <= 1'b0;
      end else if (cnt_reg != BIT_CW'(WORD_BITS)) begin
         bit_reg <= word_i[idx];
         cnt_reg <= cnt_reg + 1'b1;
      end
   end

   // done only after the host has sampled the last bit on its rising edge
   always_ff @(posedge sclk_i or posedge clear_i) begin
      if (clear_i) begin
         done_o <= 1'b0;
      end else if (cnt_reg == BIT_CW'(WORD_BITS)) begin
         done_o <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_done_full_word: assert property ( // RL17
      @(posedge sclk_i) disable iff (clear_i)
      done_o |-> cnt_reg == BIT_CW'(WORD_BITS))
      else $error("done raised before full word shifted");

endmodule // pcs_serial_shift

// ==== verif/pcs_host_model.sv ====
// host model: serial reader that clocks one 32-bit word out of the pin
`timescale 1ns/1ps
module pcs_host_model (
   input  wire logic        req_i,   // start one read
   input  wire logic        pin_i,   // resolved ready/data pin
   output logic             sclk_o,  // serial clock, parked high between frames
   output logic [31:0]      word_o,  // bits taken, first one ends in the msb
   output logic             done_o   // read finished, held until req drops
);
   // ----------------------------------------------------------------
   // reader
   // ----------------------------------------------------------------
   initial begin
      sclk_o = 1'b1;
      word_o = '0;
      done_o = 1'b0;
   end
   // whole word per request; the bench starts reads only when allowed
   always begin
      wait (req_i === 1'b1);
      for (int i = 0; i < 32; i++) begin
         #7.5 sclk_o = 1'b0;                 // device moves data on the fall
         #7.5 sclk_o = 1'b1;                 // host samples on the rise
         word_o = {word_o[30:0], pin_i};
      end
      done_o = 1'b1;
      wait (req_i === 1'b0);
      done_o = 1'b0;
   end
endmodule // pcs_host_model

// ==== verif/test_pin_controlled_conversion_sequencer.sv ====
// testbench of the conversion sequencer with a serial host model
`timescale 1ns/1ps
module test_pin_controlled_conversion_sequencer;
   // ----------------------------------------------------------------
   // parameters and signals
   // ----------------------------------------------------------------
   localparam int WK = 20;    // shortened wake
   localparam int FP = 200;   // shortened fast period
   localparam int SP = 300;   // shortened slow period
   localparam int LD = 20;    // shortened ready lead
   logic        clock_i = 1'b0;
   logic        arst_n_i = 1'b0;
   logic        pd_n = 1'b0;
   logic        filt = 1'b0;
   logic [23:0] res = 24'hA5C3E1;
   logic        req = 1'b0;
   wire         sclk, done, sw, mrst, rdy, oe, fast, pin;
   wire  [31:0] word;
   int          n_mismatch = 0;
   int          tests_run = 0;
   int          cyc = 0;
   // pin floats when the device lets go
   assign pin = oe ? rdy : 1'bz;
   always #4 clock_i = ~clock_i;
   // cycle count and hang limit
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         n_mismatch++;
         complete_run();
      end
   end
   pcs_sequencer #(.WAKE_CYC_P(WK), .FAST_CYC_P(FP), .SLOW_CYC_P(SP), .LEAD_CYC_P(LD))
   pcs_sequencer_inst (
      .clock_i(clock_i), .arst_n_i(arst_n_i), .power_down_reset_n_i(pd_n),
      .filter_sel_i(filt), .sclk_i(sclk), .filter_result_i(res),
      .bridge_switch_o(sw), .mod_reset_o(mrst), .dout_rdy_o(rdy),
      .dout_rdy_oe_o(oe), .filter_fast_o(fast));
   pcs_host_model pcs_host_model_inst (
      .req_i(req), .pin_i(pin), .sclk_o(sclk), .word_o(word), .done_o(done));
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic tick();
      @(posedge clock_i);
      #1;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // waits for the pin to reach a level, counting cycles
   task automatic wait_rdy(input logic lvl, output int n);
      n = 0;
      while (rdy !== lvl && n < 2000) begin
         tick();
         n++;
      end
   endtask
   task automatic host_read(output logic [31:0] w);
      int n;
      req = 1'b1;
      n = 0;
      while (done !== 1'b1 && n < 200) begin
         tick();
         n++;
      end
      w = word;
      req = 1'b0;
      tick();
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   // power-down held, then release and first settled result
   task automatic t_power_up();
      int t0, n;
      check(oe, 1'b0);
      check(sw, 1'b0);
      check(mrst, 1'b1);
      pd_n = 1'b1;
      t0 = cyc;
      repeat (4) tick();
      check({sw, oe, rdy, fast}, 4'hF);
      wait_rdy(1'b0, n);
      n = cyc - t0;
      check(n >= WK + 2 * FP - 2 && n <= WK + 2 * FP + 8, 1'b1);
   endtask
   // word read after a fresh result: value then status, then a repeat read sees ones
   task automatic t_read(input logic fsel);
      logic [31:0] w;
      int          n;
      host_read(w);
      check(w, {res, 4'h0, fsel, 3'h5});
      wait_rdy(1'b1, n);
      check(n < 10, 1'b1);
      repeat (4) tick();
      host_read(w);
      check(w, 32'hFFFFFFFF);
   endtask
   // unread results: lead rise, exact spacing, new value stored
   task automatic t_period();
      int a, b;
      wait_rdy(1'b0, a);
      res = 24'h3C0F5A;
      wait_rdy(1'b1, a);
      wait_rdy(1'b0, b);
      check(a + b, FP);
      check(b >= LD && b <= LD + 3, 1'b1);
      t_read(1'b0);
   endtask
   // filter change: restart, ones during settle, slow settle time
   task automatic t_filter();
      logic [31:0] w;
      logic        seen;
      int          t0, n;
      wait_rdy(1'b0, n);
      filt = 1'b1;
      t0 = cyc;
      seen = 1'b0;
      repeat (6) begin
         tick();
         if (mrst === 1'b1) seen = 1'b1;
      end
      check(seen, 1'b1);
      check({fast, rdy}, 2'h1);
      host_read(w);
      check(w, 32'hFFFFFFFF);
      wait_rdy(1'b0, n);
      n = cyc - t0;
      check(n >= 3 * SP - 2 && n <= 3 * SP + 8, 1'b1);
      t_read(1'b1);
   endtask
   // power-down in mid-run
   task automatic t_power_down();
      pd_n = 1'b0;
      repeat (4) tick();
      check({oe, sw, mrst}, 3'h1);
   endtask
   // ----------------------------------------------------------------
   // closing and main sequence
   // ----------------------------------------------------------------
   task automatic complete_run();
      $display("mismatches %0d of %0d comparisons", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (2) tick();
      arst_n_i = 1'b1;
      repeat (3) tick();
      t_power_up();
      t_read(1'b0);
      t_period();
      t_filter();
      t_power_down();
      complete_run();
   end
endmodule // test_pin_controlled_conversion_sequencer
